// [hw/fsw_watchdog.sv]
// Purpose: fail-safe watchdog guarding two supplementary relays, with diagnostic
// Assumes: keep-alive and setup commands come from logic on mclk_i;
//          relay contact feedback and the stable flag are outside pins
// Notes:   timeout is a parameter so simulation may shorten it
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - after reset no relay energizes until readings are flagged stable
// - watchdog expiry forces both relays de-energized, overriding commands
// - each keep-alive restarts timer; silence lets it expire by itself
// - diagnostic samples both relay contacts for up to DIAG_CYCLES, waiting for the processor's setup to show as both energized
// - relays not responding in diagnostic report an error, no timing
// - responding relays lead to measuring fail-safe response in milliseconds
// - time spans last keep-alive received until both relays de-energized
// - one status output per relay, high while energized
module fsw_watchdog
  import fsw_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = fsw_pkg::TIMEOUT_CYC,    // must exceed the keep-alive period
  parameter int unsigned DIAG_CYCLES    = fsw_pkg::DIAG_WAIT_CYC,
  parameter int unsigned MS_CYCLES      = fsw_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    sys_rst_i,
  // processor side
  input  wire logic                    keepalive_i,
  input  wire logic                    readings_stable_i,
  input  wire fsw_pkg::fsw_relay_cmd_t relay_cmd_i,
  input  wire logic                    diag_start_i,
  // relay pins
  input  wire logic [1:0]              relay_fb_i,
  output logic      [1:0]              relay_drive_o,
  output logic      [1:0]              relay_status_o,
  // watchdog and diagnostic report
  output logic                         wd_fired_o,
  output fsw_pkg::fsw_diag_res_t       diag_res_o
);
  import fsw_pkg::*;

  // ----------------------------------------------------------------------
  // types and state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FSW_IDLE, FSW_SETUP_WAIT, FSW_ARM, FSW_MEASURE
  } fsw_diag_t;

  typedef struct packed {
    logic [31:0]     wd_cnt;
    logic            fired;
    logic            armed;    // keep-alive seen since expiry
    logic [1:0]      relay;
    logic [1:0]      status;
    fsw_diag_t       diag;
    logic [31:0]     diag_cnt;
    logic [31:0]     ms_div;
    logic [MS_W-1:0] ms;
    fsw_diag_res_t   res;
  } fsw_state_t;

  fsw_state_t st;
  fsw_state_t next_st;
  logic [1:0] fb;
  logic       stable;

  // outside levels pass the filtered synchroniser
  fsw_sync3 u_sync_fb0 (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(relay_fb_i[0]), .sync_o(fb[0]));
  fsw_sync3 u_sync_fb1 (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(relay_fb_i[1]), .sync_o(fb[1]));
  fsw_sync3 u_sync_stb (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .async_i(readings_stable_i), .sync_o(stable));

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.res.done = 1'b0;
    // keep-alive restarts the timer, silence runs it to expiry
    if (keepalive_i) begin
      next_st.wd_cnt = '0;
      next_st.fired  = 1'b0;
      next_st.armed  = 1'b1;
    end else if (st.wd_cnt >= TIMEOUT_CYCLES - 1) begin
      next_st.fired  = 1'b1;
      next_st.armed  = 1'b0;
    end else begin
      next_st.wd_cnt = st.wd_cnt + 32'h1;
    end
    // a setup command only lands once stable and the watchdog is rearmed
    if (relay_cmd_i.valid && stable && st.armed && !st.fired) begin
      next_st.relay = relay_cmd_i.state;
    end
    if (!stable) begin
      next_st.relay = 2'b00;
    end
    if (next_st.fired) begin
      next_st.relay = 2'b00;                                 // expiry overrides
    end
    next_st.status = fb;

    // diagnostic sequence
    case (st.diag)
      FSW_IDLE: begin
        if (diag_start_i) begin
          next_st.diag     = FSW_SETUP_WAIT;
          next_st.diag_cnt = '0;
        end
      end
      FSW_SETUP_WAIT: begin
        // processor issued setup; sample the contacts within the window
        if (fb == 2'b11) begin
          next_st.diag = FSW_ARM;
        end else if (st.diag_cnt >= DIAG_CYCLES - 1) begin
          next_st.diag      = FSW_IDLE;
          next_st.res.done  = 1'b1;
          next_st.res.error = 1'b1;
          next_st.res.ms    = '0;
        end else begin
          next_st.diag_cnt = st.diag_cnt + 32'h1;
        end
      end
      FSW_ARM: begin
        // timing begins at the keep-alive the reset logic receives
        if (keepalive_i) begin
          next_st.diag   = FSW_MEASURE;
          next_st.ms_div = '0;
          next_st.ms     = '0;
        end
      end
      FSW_MEASURE: begin
        if (keepalive_i) begin
          next_st.ms_div = '0;                               // restart on later pulses
          next_st.ms     = '0;
        end else if (fb == 2'b00) begin
          next_st.diag      = FSW_IDLE;
          next_st.res.done  = 1'b1;
          next_st.res.error = 1'b0;
          next_st.res.ms    = st.ms;
        end else if (st.ms_div >= MS_CYCLES - 1) begin
          next_st.ms_div = '0;
          next_st.ms     = st.ms + 1'b1;
          // relays stuck energized: give up with an error
          if (st.ms >= MS_W'(RESP_LIMIT_MS)) begin
            next_st.diag      = FSW_IDLE;
            next_st.res.done  = 1'b1;
            next_st.res.error = 1'b1;
            next_st.res.ms    = '0;                          // error, so no timing result
          end
        end else begin
          next_st.ms_div = st.ms_div + 32'h1;
        end
      end
      default: next_st.diag = FSW_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      // whole-struct clear: an enum member refuses a defaulted integral pattern
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign relay_drive_o  = st.relay;
  assign relay_status_o = st.status;
  assign wd_fired_o     = st.fired;
  assign diag_res_o     = st.res;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  initial begin
    chk_timeout_longer: assert (TIMEOUT_MS > KEEPALIVE_MS)
      else $error("watchdog timeout not longer than keep-alive period");
  end

  chk_unstable_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !stable |=> relay_drive_o == 2'b00)
    else $error("relay energized before readings stable");

  chk_fire_forces: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wd_fired_o |-> relay_drive_o == 2'b00)
    else $error("relay energized while watchdog fired");

  chk_kick_restarts: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    keepalive_i |=> !wd_fired_o && st.wd_cnt == 0)
    else $error("keep-alive did not restart watchdog");

  chk_expiry_fires: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !keepalive_i && st.wd_cnt == TIMEOUT_CYCLES - 1 |=> wd_fired_o)
    else $error("watchdog did not fire at timeout");

  sequence s_diag_begin;
    st.diag == FSW_IDLE && diag_start_i;
  endsequence
  chk_diag_setup: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_diag_begin |=> st.diag == FSW_SETUP_WAIT)
    else $error("diagnostic did not enter setup wait");

  chk_diag_error: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st.diag == FSW_SETUP_WAIT && fb != 2'b11 && st.diag_cnt >= DIAG_CYCLES - 1
    |=> diag_res_o.done && diag_res_o.error && diag_res_o.ms == 0)
    else $error("unresponsive relays not reported as error");

  sequence s_relays_drop;
    st.diag == FSW_MEASURE && !keepalive_i && fb == 2'b00;
  endsequence
  chk_diag_time: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_relays_drop |=> diag_res_o.done && !diag_res_o.error && diag_res_o.ms == $past(st.ms))
    else $error("response time not reported");

  chk_measure_start: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st.diag == FSW_ARM && keepalive_i |=> st.diag == FSW_MEASURE && st.ms == 0 && st.ms_div == 0)
    else $error("measurement did not start at keep-alive");

  chk_status_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ##1 relay_status_o == $past(fb))
    else $error("relay status does not follow contacts");

  chk_stay_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wd_fired_o && relay_drive_o == 2'b00 && !keepalive_i |=> relay_drive_o == 2'b00)
    else $error("relay energized after expiry without keep-alive");
endmodule
`default_nettype wire

// [shared/fsw_pkg.sv]
// Purpose: shared constants and carrier types for the fail-safe relay watchdog
// Assumes: 250 MHz system clock
// Notes:   times are kept in their own unit, cycle counts derive from them
`default_nettype none
package fsw_pkg;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned MS_PER_SEC    = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_SEC;
  localparam int unsigned KEEPALIVE_MS  = 10;
  localparam int unsigned TIMEOUT_MS    = 15;
  localparam int unsigned TIMEOUT_CYC   = TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned DIAG_WAIT_MS  = 1;
  localparam int unsigned DIAG_WAIT_CYC = DIAG_WAIT_MS * CYC_PER_MS;
  localparam int unsigned MS_W          = 16;
  localparam int unsigned RESP_LIMIT_MS = 100;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       valid;  // one-cycle pulse
    logic [1:0] state;  // bit0 relay c, bit1 relay d; 1 = energized
  } fsw_relay_cmd_t;

  typedef struct packed {
    logic            done;   // one-cycle pulse
    logic            error;  // relays never responded, or stayed energized past RESP_LIMIT_MS
    logic [MS_W-1:0] ms;     // response time in milliseconds
  } fsw_diag_res_t;
endpackage
`default_nettype wire

// [hw/fsw_sync3.sv]
// Purpose: three-flop synchroniser with agreement filter for an outside level
// Assumes: input is asynchronous to mclk_i
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module fsw_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // level
  input  wire logic async_i,
  output logic      sync_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } fsw_sync_st_t;

  fsw_sync_st_t st;
  fsw_sync_st_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st    = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.q;
endmodule
`default_nettype wire

// [verification/fsw_proc_model.sv]
// Purpose: processor and relay-contact stand-in for the fail-safe watchdog
// Assumes: enable sampled on mclk_i rising edge, keep-alive changes on falling edge, contacts on rising edge
// Notes:   a stuck board keeps both contacts open whatever the drive says
`timescale 1ns/1ns
`default_nettype none
module fsw_proc_model #(
  parameter int unsigned PERIOD = 100
) (
  // clock
  input  wire logic       mclk_i,
  // bench controls
  input  wire logic       ka_en_i,
  input  wire logic       stuck_i,
  // relay side
  input  wire logic [1:0] drive_i,
  output logic            keepalive_o,
  output logic      [1:0] fb_o
);
  int unsigned cnt  = 0;
  logic        fire = 1'b0;
  logic [5:0]  lag  = 6'h0;
  // pulse at once on enable, then every period; period stays under the timeout
  always @(posedge mclk_i) begin
    fire <= ka_en_i && cnt == 0;
    cnt  <= (!ka_en_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
  end
  // launch on the falling edge so the watchdog never sees a racing pulse
  always @(negedge mclk_i) keepalive_o <= fire;
  // contacts settle three cycles behind the coil drive
  always @(posedge mclk_i) lag <= {lag[3:0], drive_i};
  assign fb_o = stuck_i ? 2'h0 : lag[5:4];
endmodule
`default_nettype wire

// [verification/fsw_watchdog_bench.sv]
// Purpose: self-checking bench for the fail-safe relay watchdog
// Assumes: short timeout parameters; keep-alive period 100 cycles
// Notes:   inputs change on the falling edge, outputs read there too
`timescale 1ns/1ns
`default_nettype none
module fsw_watchdog_bench;
  import fsw_pkg::*;
  localparam int unsigned TO_CYC = 200;
  localparam int unsigned MS_CYC = 10;
  logic           mclk_i = 1'b0, sys_rst_i = 1'b1, stable = 1'b0;
  logic           diag_start = 1'b0, ka_en = 1'b0, stuck = 1'b0, keepalive, fired;
  logic [1:0]     fb, drive, status;
  fsw_relay_cmd_t cmd = '0;
  fsw_diag_res_t  res;
  int             bad_count = 0, cmp_count = 0, n;

  fsw_proc_model #(.PERIOD(100)) PM (.mclk_i(mclk_i), .ka_en_i(ka_en), .stuck_i(stuck),
    .drive_i(drive), .keepalive_o(keepalive), .fb_o(fb));
  fsw_watchdog #(.TIMEOUT_CYCLES(TO_CYC), .DIAG_CYCLES(50), .MS_CYCLES(MS_CYC)) DUT (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .keepalive_i(keepalive), .readings_stable_i(stable),
    .relay_cmd_i(cmd), .diag_start_i(diag_start), .relay_fb_i(fb), .relay_drive_o(drive),
    .relay_status_o(status), .wd_fired_o(fired), .diag_res_o(res));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge mclk_i);
  endtask
  // setup command is a one-cycle strobe
  task automatic send(input logic [1:0] st);
    cmd <= '{valid: 1'b1, state: st};
    tick(1);
    cmd <= '0;
  endtask
  task automatic start_diag;
    diag_start <= 1'b1;
    tick(1);
    diag_start <= 1'b0;
    send(2'h3);
  endtask
  // done is a single-cycle pulse, so poll every falling edge with a bound
  task automatic wait_done;
    n = 0;
    while (res.done !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(16'(res.done), 16'h1, "diag done");
  endtask
  task automatic results;
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_powerup;
    ka_en <= 1'b1;
    tick(3);
    send(2'h3);
    tick(2);
    chk(16'(drive), 16'h0, "drive before stable");
    stable <= 1'b1;
    tick(8);
    send(2'h3);
    tick(1);
    chk(16'(drive), 16'h3, "drive after setup");
    tick(10);
    chk(16'(status), 16'h3, "status energized");
  endtask
  task automatic t_alive;
    tick(TO_CYC * 5);
    chk(16'(fired), 16'h0, "fired with keep-alive");
    chk(16'(drive), 16'h3, "drive with keep-alive");
  endtask
  task automatic t_expire;
    ka_en <= 1'b0;
    n = 0;
    while (fired !== 1'b1 && n < 2 * TO_CYC) begin
      tick(1);
      n++;
    end
    chk(16'(fired), 16'h1, "no expiry");
    chk(16'(drive), 16'h0, "drive at expiry");
    send(2'h3);
    tick(10);
    chk(16'(drive), 16'h0, "setup while fired");
    chk(16'(status), 16'h0, "status released");
    ka_en <= 1'b1;
    tick(4);
    chk(16'(fired), 16'h0, "fired after resume");
    chk(16'(drive), 16'h0, "drive after resume");
    send(2'h3);
    tick(1);
    chk(16'(drive), 16'h3, "setup after resume");
  endtask
  task automatic t_diag_err;
    stuck <= 1'b1;
    // let the open contacts pass the synchroniser before the diagnostic looks
    tick(10);
    start_diag;
    wait_done;
    chk(16'(res.error), 16'h1, "stuck relays error");
    chk(res.ms, 16'h0, "stuck relays time");
    stuck <= 1'b0;
    tick(10);
  endtask
  task automatic t_diag_ok;
    ka_en <= 1'b0;
    start_diag;
    tick(15);
    ka_en <= 1'b1;
    tick(1);
    ka_en <= 1'b0;
    wait_done;
    chk(16'(res.error), 16'h0, "responding relays error");
    // contact and sync tail after expiry is about eight cycles, under one ms
    chk(res.ms, 16'(TO_CYC / MS_CYC), "response ms");
  endtask

  // ----------------------------------------------------------------------
  // run
  // ----------------------------------------------------------------------
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  initial begin
    tick(6);
    sys_rst_i <= 1'b0;
    t_powerup;
    t_alive;
    t_diag_err;
    t_expire;
    t_diag_ok;
    results;
  end
  // whole run is near 1500 cycles, so this only trips on a hang
  initial begin
    tick(20000);
    bad_count++;
    $display("mismatch at %0t: run hung", $time);
    results;
  end
endmodule
`default_nettype wire
